// ===== design/lcdw_core.sv
// serial display ram writer with power-on and software reset
// Functional notes
// R1: narrow package: columns 0-3 and 31-34 are written but never drive outputs.
// R2: ball package: columns 0,1,33,34 are written but never drive outputs.
// R3: ram written per nibble; partial nibble dropped when chip select rises.
// R4: power-on reset and software reset both restore the initial state.
// R5: software reset turns the display off.
// R6: software reset clears the address pointer, keeps ram contents.
// R7: software reset returns every command field to its initial value.
// R8: host without clean power-up toggles chip select then issues software reset.
// R9: address advances per nibble, wrapping from 22h to 00h.
// R10: bits sampled on serial clock rise, msb first, byte formed after eighth.
// R11: leading bit selects command or data; chip select high clears bit count.
// R12: host requests software reset with operation command bit P1 set.
// R13: each address holds four bits, bit n drives common n.
`default_nettype none
module lcdw_core
   import lcdw_pkg::*;
#(
   parameter int SEGS = lcdw_pkg::LCDW_SEGS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // serial link pins
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   // package strap
   input wire logic [1:0] package_variant,
   // configuration and display ram view
   output lcdw_pkg::lcdw_cfg_s cfg,
   output logic [lcdw_pkg::LCDW_AW-1:0] ram_addr,
   output logic [SEGS-1:0][lcdw_pkg::LCDW_COMS-1:0] segment_output
);
   import lcdw_pkg::*;

   if (SEGS != LCDW_SEGS) begin : g_chk
      $error("lcdw_core: segment count must match the address map");
   end

   logic [2:0] cs_sync_r, sck_sync_r;
   logic [1:0] sd_sync_r;
   logic cs_n, sck_rise, sd;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cs_sync_r <= 3'h7;
         sck_sync_r <= 3'h0;
         sd_sync_r <= 2'h0;
      end else begin
         cs_sync_r <= {cs_sync_r[1:0], chip_select_n};
         sck_sync_r <= {sck_sync_r[1:0], serial_clk};
         sd_sync_r <= {sd_sync_r[0], serial_data_in};
      end
   end
   // stage 0 feeds only stage 1; logic reads stage 1 and later
   assign cs_n = cs_sync_r[1];
   assign sd = sd_sync_r[1];
   assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];

   // strap is a pin too: two flops before the column masks read it
   logic [1:0] pv_meta_r, pv_sync_r;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pv_meta_r <= LCDW_PKG_FULL;
         pv_sync_r <= LCDW_PKG_FULL;
      end else begin
         pv_meta_r <= package_variant;
         pv_sync_r <= pv_meta_r;
      end
   end

   // serial shifter: first bit of each byte is the command/data marker
   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   logic is_cmd;
   logic byte_done;
   logic [7:0] byte_val;
   assign byte_done = ~cs_n & sck_rise & (bit_cnt_r == LCDW_BIT_LAST); // R10
   assign byte_val = {shift_r, sd}; // R10
   always_ff @(posedge sys_clk) begin
      if (srst | cs_n) begin
         bit_cnt_r <= 3'h0; // R11
         shift_r <= 7'h00;
      end else if (sck_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shift_r <= {shift_r[5:0], sd}; // R10
      end
   end
   // the msb of each byte picks command or data for that byte
   assign is_cmd = byte_val[7]; // R11

   logic cmd_stb, data_stb, sw_reset;
   assign cmd_stb = byte_done & is_cmd;
   assign data_stb = byte_done & ~is_cmd;
   assign sw_reset = cmd_stb && (byte_val[6:3] == LCDW_OP_OPSET) && byte_val[LCDW_POS_SWRST]; // R12

   // configuration fields
   lcdw_cfg_s cfg_r;
   always_ff @(posedge sys_clk) begin
      if (srst || sw_reset) begin
         cfg_r <= LCDW_CFG_RST; // R4 R5 R7
      end else if (cmd_stb) begin
         if (byte_val[6:5] == LCDW_OP_MODE) begin
            cfg_r.display_on <= byte_val[3];
            cfg_r.half_bias <= byte_val[2];
         end else if (byte_val[6:5] == LCDW_OP_DISCTL) begin
            cfg_r.frame_rate <= byte_val[4:3];
            cfg_r.frame_inv <= byte_val[2];
            cfg_r.power_mode <= byte_val[1:0];
         end else if (byte_val[6:3] == LCDW_OP_OPSET) begin
            cfg_r.addr_msb <= byte_val[LCDW_POS_AMSB];
            cfg_r.ext_clock <= byte_val[0];
         end else if (byte_val[6:3] == LCDW_OP_BLINK) begin
            cfg_r.blink <= byte_val[1:0];
         end else if (byte_val[6:2] == LCDW_OP_APCTL) begin
            cfg_r.all_on <= byte_val[1];
            cfg_r.all_off <= byte_val[0];
         end
      end
   end
   assign cfg = cfg_r;

   // address pointer; each data byte carries two nibbles
   logic [LCDW_AW-1:0] addr_r;
   logic [LCDW_AW-1:0] addr_inc;
   function automatic logic [LCDW_AW-1:0] lcdw_next(input logic [LCDW_AW-1:0] a);
      lcdw_next = (a >= LCDW_ADDR_LAST) ? LCDW_ADDR_FIRST : a + 6'h01; // R9
   endfunction
   assign addr_inc = lcdw_next(addr_r);
   // nibble strobe: upper nibble after fourth data bit, lower after eighth
   logic nib_hi_stb;
   logic data_frame_r;
   always_ff @(posedge sys_clk) begin
      if (srst | cs_n) begin
         data_frame_r <= 1'b0;
      end else if (sck_rise && bit_cnt_r == 3'h0) begin
         data_frame_r <= ~sd;
      end
   end
   assign nib_hi_stb = ~cs_n & sck_rise & data_frame_r & (bit_cnt_r == 3'h3); // R3
   // a cut nibble never reaches its strobe, so there is nothing to undo
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addr_r <= LCDW_ADDR_FIRST; // R4
      end else if (sw_reset) begin
         addr_r <= LCDW_ADDR_FIRST; // R6
      end else if (cmd_stb && byte_val[6:5] == LCDW_OP_ADDRESS_SET_COMMAND) begin
         addr_r <= {cfg_r.addr_msb, byte_val[4:0]};
      end else if (nib_hi_stb) begin
         addr_r <= addr_inc; // R9
      end else if (data_stb) begin
         addr_r <= addr_inc; // R9
      end
   end
   assign ram_addr = addr_r;

   // display ram: contents survive software reset
   logic [LCDW_COMS-1:0] ram_r [SEGS];
   logic [LCDW_AW-1:0] wr_addr;
   logic [3:0] wr_data;
   logic wr_en;
   assign wr_en = nib_hi_stb | data_stb; // R3
   assign wr_data = nib_hi_stb ? {shift_r[2:0], sd} : byte_val[3:0];
   assign wr_addr = addr_r;
   always_ff @(posedge sys_clk) begin
      if (wr_en && wr_addr <= LCDW_ADDR_LAST) begin
         ram_r[wr_addr] <= wr_data; // R3 R6
      end
   end

   // per-column output with dummy masking for reduced packages
   for (genvar s = 0; s < SEGS; s++) begin : g_seg
      logic dummy;
      assign dummy = (pv_sync_r == LCDW_PKG_NARROW &&
                        (6'(s) <= LCDW_NARROW_LO || 6'(s) >= LCDW_NARROW_HI)) || // R1
                     (pv_sync_r == LCDW_PKG_BALL &&
                        (6'(s) <= LCDW_BALL_LO || 6'(s) >= LCDW_BALL_HI)); // R2
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            segment_output[s] <= 4'h0;
         end else begin
            segment_output[s] <= dummy ? 4'h0 : ram_r[s]; // R13
         end
      end
   end

   // checks
   sw_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      sw_reset |=> !cfg.display_on && ram_addr == LCDW_ADDR_FIRST) // R5
      else $error("software reset left display on or pointer set");
   wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
      (wr_en && ram_addr == LCDW_ADDR_LAST && !sw_reset) |=> ram_addr == LCDW_ADDR_FIRST) // R9
      else $error("address did not wrap");
   nib_step_a: assert property (@(posedge sys_clk) disable iff (srst)
      nib_hi_stb |=> ram_addr == $past(addr_inc)) // R9
      else $error("pointer did not advance on upper nibble");
   data_cfg_a: assert property (@(posedge sys_clk) disable iff (srst)
      data_stb |=> $stable(cfg)) // R11
      else $error("data byte changed configuration");
   cfg_rst_a: assert property (@(posedge sys_clk) disable iff (srst)
      sw_reset |=> cfg == LCDW_CFG_RST) // R7
      else $error("configuration not restored");
   bit_clr_a: assert property (@(posedge sys_clk) disable iff (srst)
      cs_n |=> bit_cnt_r == 3'h0) // R11
      else $error("bit counter not cleared");
   ram_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
      sw_reset |=> ram_r[0] == $past(ram_r[0])) // R6
      else $error("ram changed by software reset");
   nib_drop_a: assert property (@(posedge sys_clk) disable iff (srst)
      (cs_n && !wr_en) |=> $stable(ram_addr) || $past(cmd_stb)) // R3
      else $error("pointer moved without a full nibble");
   narrow_a: assert property (@(posedge sys_clk) disable iff (srst)
      (pv_sync_r == LCDW_PKG_NARROW)[*2] |-> segment_output[0] == 4'h0 && segment_output[34] == 4'h0) // R1
      else $error("dummy column drove output");
   ball_a: assert property (@(posedge sys_clk) disable iff (srst)
      (pv_sync_r == LCDW_PKG_BALL)[*2] |-> segment_output[1] == 4'h0 && segment_output[33] == 4'h0) // R2
      else $error("dummy column drove output");
   por_a: assert property (@(posedge sys_clk) srst |=> cfg == LCDW_CFG_RST && ram_addr == LCDW_ADDR_FIRST) // R4
      else $error("power-on state wrong");
   cov_data_c: cover property (@(posedge sys_clk) disable iff (srst) data_stb);
   cov_swrst_c: cover property (@(posedge sys_clk) disable iff (srst) sw_reset);
   cov_wrap_c: cover property (@(posedge sys_clk) disable iff (srst) wr_en && ram_addr == LCDW_ADDR_LAST);
   cov_blank_c: cover property (@(posedge sys_clk) disable iff (srst) pv_sync_r != LCDW_PKG_FULL && wr_en);
   cov_part_c: cover property (@(posedge sys_clk) disable iff (srst) nib_hi_stb ##[1:40] cs_n);
endmodule
`default_nettype wire

// ===== common/lcdw_pkg.sv
// shared constants and types for the lcd display ram write and reset block
`default_nettype none
package lcdw_pkg;
   localparam int LCDW_SEGS = 35;
   localparam int LCDW_COMS = 4;
   localparam int LCDW_AW = 6;
   localparam logic [5:0] LCDW_ADDR_LAST = 6'h22;
   localparam logic [5:0] LCDW_ADDR_FIRST = 6'h00;
   localparam logic [2:0] LCDW_BIT_LAST = 3'h7;
   // package variants
   localparam logic [1:0] LCDW_PKG_FULL = 2'h0;
   localparam logic [1:0] LCDW_PKG_NARROW = 2'h1;
   localparam logic [1:0] LCDW_PKG_BALL = 2'h2;
   localparam logic [5:0] LCDW_NARROW_LO = 6'h03;
   localparam logic [5:0] LCDW_NARROW_HI = 6'h1F;
   localparam logic [5:0] LCDW_BALL_LO = 6'h01;
   localparam logic [5:0] LCDW_BALL_HI = 6'h21;
   // command decode fields
   localparam logic [1:0] LCDW_OP_MODE = 2'h2;
   localparam logic [2:0] LCDW_OP_OPERATION_SET_COMMAND_HI = 3'h6;
   localparam logic [1:0] LCDW_OP_ADDRESS_SET_COMMAND = 2'h0;
   localparam logic [1:0] LCDW_OP_DISCTL = 2'h1;
   localparam logic [3:0] LCDW_OP_OPSET = 4'hD;
   localparam logic [3:0] LCDW_OP_BLINK = 4'hE;
   localparam logic [4:0] LCDW_OP_APCTL = 5'h1F;
   localparam int LCDW_POS_SWRST = 1;
   localparam int LCDW_POS_AMSB = 2;
   localparam logic [1:0] LCDW_PSAVE_RST = 2'h2;
   typedef struct packed {
      logic display_on;
      logic half_bias;
      logic [1:0] frame_rate;
      logic frame_inv;
      logic [1:0] power_mode;
      logic addr_msb;
      logic ext_clock;
      logic [1:0] blink;
      logic all_on;
      logic all_off;
   } lcdw_cfg_s;
   localparam lcdw_cfg_s LCDW_CFG_RST = '{1'b0, 1'b0, 2'h0, 1'b0, LCDW_PSAVE_RST,
                                           1'b0, 1'b0, 2'h0, 1'b0, 1'b0};
endpackage
`default_nettype wire

// ===== sim/lcdw_host.sv
// host model driving the three-wire serial link
`default_nettype none
module lcdw_host (
   // clock
   input wire logic sys_clk,
   // serial link pins
   output logic chip_select_n,
   output logic serial_clk,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // four cycles a phase: three for the synchroniser, one spare
   localparam int HALF = 4;
   initial begin
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
      serial_data_in = 1'b1;
   end
   // chip select high restarts the bit count; the host toggles it before a reset
   task automatic frame(input logic sel_n);
      repeat (HALF) @(negedge sys_clk);
      chip_select_n = sel_n;
      if (sel_n)
         serial_data_in = ~serial_data_in; // released line shows no stale bit
      repeat (HALF) @(negedge sys_clk);
   endtask
   // msb first, marker bit leads, data steady across the rising edge
   task automatic send(input logic [7:0] val, input int nbits);
      for (int i = 7; i > 7 - nbits; i--) begin
         serial_data_in = val[i];
         repeat (HALF) @(negedge sys_clk);
         serial_clk = 1'b1;
         repeat (HALF) @(negedge sys_clk);
         serial_clk = 1'b0;
      end
      repeat (2) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ===== sim/test_lcdw_core.sv
// self-checking bench for the display ram writer
`default_nettype none
module test_lcdw_core;
   timeunit 1ns;
   timeprecision 1ps;
   import lcdw_pkg::*;
   logic sys_clk;
   logic srst;
   logic [1:0] package_variant;
   wire chip_select_n;
   wire serial_clk;
   wire serial_data_in;
   lcdw_cfg_s cfg;
   logic [5:0] ram_addr;
   logic [139:0] segment_output;
   lcdw_cfg_s exp_cfg;
   int mem [35];
   int addr;
   int n_fail = 0;
   int n_compared = 0;
   logic [7:0] b;
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   lcdw_host host (.sys_clk(sys_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in));
   lcdw_core DUT (.sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .package_variant(package_variant), .cfg(cfg), .ram_addr(ram_addr),
      .segment_output(segment_output));
   task automatic check(input string what, input logic [139:0] seen, input logic [139:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // dummy columns of the reduced packages read zero
   function automatic logic [139:0] exp_seg();
      logic [139:0] v;
      v = '0;
      for (int s = 0; s < 35; s++) begin
         if (!(package_variant == 2'h1 && (s < 4 || s > 30)) && !(package_variant == 2'h2 && (s < 2 || s > 32)))
            v[s*4 +: 4] = 4'(mem[s]);
      end
      return v;
   endfunction
   task automatic check_all(input string what);
      check({what, " cfg"}, 140'(cfg), 140'(exp_cfg));
      check({what, " addr"}, 140'(ram_addr), 140'(addr));
      check({what, " seg"}, segment_output, exp_seg());
   endtask
   task automatic wr_nib(input logic [3:0] n);
      mem[addr] = int'(n);
      addr = (addr == 34) ? 0 : addr + 1;
   endtask
   task automatic put_byte(input logic [7:0] v);
      host.send(v, 8);
      if (!v[7]) begin
         wr_nib(v[7:4]);
         wr_nib(v[3:0]);
      end else if (v[6:5] == 2'h0)
         addr = int'({exp_cfg.addr_msb, v[4:0]});
      else if (v[6:5] == 2'h1)
         {exp_cfg.frame_rate, exp_cfg.frame_inv, exp_cfg.power_mode} = v[4:0];
      else if (v[6:5] == 2'h2)
         {exp_cfg.display_on, exp_cfg.half_bias} = v[3:2];
      else if (v[6:3] == 4'hD && v[1]) begin
         exp_cfg = LCDW_CFG_RST;
         addr = 0;
      end else if (v[6:3] == 4'hD)
         {exp_cfg.addr_msb, exp_cfg.ext_clock} = {v[2], v[0]};
      else if (v[6:3] == 4'hE)
         exp_cfg.blink = v[1:0];
      else if (v[6:2] == 5'h1F)
         {exp_cfg.all_on, exp_cfg.all_off} = v[1:0];
      repeat (6) @(negedge sys_clk);
   endtask
   // ram is kept through reset, only the view is blanked
   task automatic por(input int n);
      srst = 1'b1;
      repeat (n) @(negedge sys_clk);
      exp_cfg = LCDW_CFG_RST;
      addr = 0;
      check("por cfg", 140'(cfg), 140'(exp_cfg));
      check("por addr", 140'(ram_addr), 140'(addr));
      check("por seg", segment_output, 140'(0));
      srst = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      package_variant = 2'h0;
      void'($urandom(45));
      por(16);
      $display("test power-on done");
      host.frame(1'b0);
      put_byte(8'h80);
      repeat (18) put_byte(8'($urandom()) & 8'h7F);
      host.frame(1'b1);
      for (int v = 0; v < 3; v++) begin
         package_variant = 2'(v);
         repeat (4) @(negedge sys_clk);
         check_all("fill");
      end
      $display("test fill done");
      host.frame(1'b0);
      put_byte(8'hEC);
      put_byte(8'h82);
      put_byte(8'($urandom()) & 8'h7F);
      check_all("wrap");
      put_byte(8'hE8);
      put_byte(8'h85);
      b = 8'($urandom()) & 8'h7F;
      host.send(b, 6);
      wr_nib(b[7:4]);
      host.frame(1'b1);
      check_all("partial");
      host.frame(1'b0);
      put_byte(b);
      check_all("resync");
      $display("test nibble done");
      put_byte(8'hE9);
      repeat (6) begin
         put_byte(8'hA0 | (8'($urandom()) & 8'h1F));
         put_byte(8'hC0 | (8'($urandom()) & 8'h1F));
         put_byte(8'hF0 | (8'($urandom()) & 8'h07));
         put_byte(8'hFC | (8'($urandom()) & 8'h03));
         check_all("config");
      end
      put_byte(8'hC8);
      host.frame(1'b1);
      host.frame(1'b0);
      put_byte(8'hEA);
      host.frame(1'b1);
      check_all("soft reset");
      $display("test soft reset done");
      package_variant = 2'h0;
      repeat (4) @(negedge sys_clk);
      check_all("dummy kept");
      $display("test dummy columns done");
      por(3);
      report_and_stop();
   end
endmodule
`default_nettype wire
